// ===== tapi_conv_ctl.sv
// Purpose: control side of a serially driven touch converter
// Assumes: host drives serial clock, chip select and control bytes
// Notes: pins are sampled by the 40 MHz core clock
//
// Behaviour
// R1: host may overlap bytes, fifteen clocks apart
// R2: result shifted out as straight binary
// R3: short mode ends four clocks sooner
// R4: host may run short mode clock faster
// R5: power bits 11 full, 00 auto power-down
// R6: single-ended drives sensor only while acquiring
// R7: differential drives sensor acquire and convert
// R8: chip select high aborts, powers down
// R9: chip select leaves reference state alone
// R10: host clears upper power bit to stop reference
// R11: auto power-down grounds y-minus, links x-plus
// R12: touch pulls pen output low
// R13: position measurement grounds pen diode, isolates x-plus
// R14: pen output is pull-down only
// R15: mode bit low twelve, high eight bits
// R16: 01 reference off, 10 converter off, 11 no pen
// R17: reference setting latched as busy rises
// R18: reference select high single-ended, low differential
// R19: bits ignored until high start bit
`timescale 1ns/1ps
`include "tapi_cfg.svh"
module tapi_conv_ctl (
  input wire logic CLOCK_I, // core clock, 40 MHz
  input wire logic RST_N_I, // sync reset, active low
  input wire logic SERIAL_CLOCK_IN_I, // serial clock from host
  input wire logic CS_N_I, // chip select, active low
  input wire logic DIN_I, // serial control data in
  input wire logic XP_SENSE_I, // x-plus panel level
  input wire logic [11:0] CONV_DATA_I, // comparator result code
  output logic DOUT_O, // serial result out
  output logic DOUT_OE_O, // result pin driven
  output logic BUSY_O, // conversion busy
  output logic BUSY_OE_O, // busy pin driven
  output logic [2:0] CHANNEL_O, // selected input channel
  output logic ACQUIRE_O, // sample/hold tracking
  output logic DRIVE_ON_O, // sensor drive switches closed
  output logic REF_ON_O, // internal reference powered
  output logic ADC_ON_O, // converter powered
  output logic SHORT_MODE_O, // eight-bit conversion selected
  output logic REF_SINGLE_O, // single-ended reference mode
  output logic YM_GND_O, // y-minus driver to ground
  output logic XP_PEN_LINK_O, // x-plus tied to pen node
  output logic PEN_TOUCH_IRQ_N_O, // pen output level, always low
  output logic PEN_TOUCH_IRQ_OE_O // pen output pulls low
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  tapi_pin_if lk (); // synchronised pin events
  tapi_pkg::tapi_conv_st_t state_q; // sequencer state
  tapi_pkg::tapi_conv_st_t state_d; // next sequencer state
  logic rx_active_q; // start bit seen, byte in flight
  logic [2:0] rx_cnt_q; // payload bits taken
  logic [6:0] rx_sh_q; // payload shift register
  logic [6:0] rx_sh_d; // payload with current bit
  logic take_bit; // payload bit sampled now
  logic refsel_bit; // reference select bit sampled now
  logic byte_done; // last payload bit sampled now
  logic acq_pend_q; // acquisition to start next fall
  logic byte_pend_q; // byte done, busy on next fall
  logic [2:0] ch_q; // latched channel
  logic short_q; // latched short mode
  logic single_q; // latched single-ended reference
  logic [1:0] power_select_q; // upper, lower power bits
  logic ref_on_q; // reference power state
  logic [11:0] res_q; // result shift register
  logic [3:0] bits_left_q; // result bits still to send
  logic dout_q; // result bit on pin
  logic busy_go; // busy rises now
  logic meas_xy; // position measurement running

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  tapi_link_sync u_sync (
    .clk_i (CLOCK_I),
    .rst_n_i (RST_N_I),
    .sclk_i (SERIAL_CLOCK_IN_I),
    .cs_n_i (CS_N_I),
    .din_i (DIN_I),
    .xp_i (XP_SENSE_I),
    .lk (lk.src)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // result length for the selected resolution
  function automatic logic [3:0] res_len(input logic short_sel);
    res_len = short_sel ? `TAPI_SHORT_BITS : `TAPI_FULL_BITS; // R15
  endfunction

  // ----------------------------------------
  // control byte receiver
  // ----------------------------------------
  assign take_bit = lk.cs_act & lk.sclk_rise & rx_active_q;
  assign rx_sh_d = {rx_sh_q[5:0], lk.din};
  assign refsel_bit = take_bit & (rx_cnt_q == 3'h4);
  assign byte_done = take_bit & (rx_cnt_q == (`TAPI_CB_PAYLOAD - 3'h1));

  // hunt for start bit, then gather seven payload bits
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I || !lk.cs_act) begin
      rx_active_q <= 1'b0;
      rx_cnt_q <= 3'h0;
    end else if (lk.sclk_rise) begin
      if (!rx_active_q) begin
        rx_active_q <= lk.din; // R19
        rx_cnt_q <= 3'h0;
      end else if (byte_done) begin
        rx_active_q <= 1'b0; // hunt again, allows overlap R1
        rx_cnt_q <= 3'h0;
      end else begin
        rx_cnt_q <= rx_cnt_q + 3'h1;
      end
    end
  end

  // payload shift register
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      rx_sh_q <= 7'h00;
    end else if (take_bit) begin
      rx_sh_q <= rx_sh_d;
    end
  end

  // channel, resolution and reference mode known after fifth bit
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      ch_q <= 3'h0;
      short_q <= 1'b0;
      single_q <= 1'b1;
    end else if (refsel_bit) begin
      ch_q <= rx_sh_d[`TAPI_CB_CH_MSB-2:`TAPI_CB_CH_LSB-2];
      short_q <= rx_sh_d[`TAPI_CB_MODE-2]; // R15
      single_q <= rx_sh_d[`TAPI_CB_REFSEL-2]; // R18
    end
  end

  // power bits close the byte
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      power_select_q <= `TAPI_PWR_RESET;
    end else if (byte_done) begin
      power_select_q <= rx_sh_d[`TAPI_CB_PWR_MSB:`TAPI_CB_PWR_LSB];
    end
  end

  // events waiting for the next falling edge
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I || !lk.cs_act) begin
      acq_pend_q <= 1'b0;
      byte_pend_q <= 1'b0;
    end else begin
      if (refsel_bit) begin
        acq_pend_q <= 1'b1;
      end else if (lk.sclk_fall) begin
        acq_pend_q <= 1'b0;
      end
      if (byte_done) begin
        byte_pend_q <= 1'b1;
      end else if (lk.sclk_fall) begin
        byte_pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    if (lk.sclk_fall) begin
      case (state_q)
        tapi_pkg::TAPI_IDLE: begin
          if (acq_pend_q) state_d = tapi_pkg::TAPI_ACQ;
        end
        tapi_pkg::TAPI_ACQ: begin
          if (byte_pend_q) state_d = tapi_pkg::TAPI_BUSY;
        end
        tapi_pkg::TAPI_BUSY: begin
          state_d = tapi_pkg::TAPI_SHIFT;
        end
        tapi_pkg::TAPI_SHIFT: begin
          if (acq_pend_q) begin
            state_d = tapi_pkg::TAPI_ACQ; // new byte takes over
          end else if (bits_left_q == 4'h0) begin
            state_d = tapi_pkg::TAPI_IDLE; // R3
          end
        end
        default: begin
          state_d = tapi_pkg::TAPI_IDLE;
        end
      endcase
    end
  end

  // gated by chip select so an abort never latches the reference
  assign busy_go = lk.cs_act & lk.sclk_fall & (state_q == tapi_pkg::TAPI_ACQ) & byte_pend_q;

  // state register, chip select high abandons the conversion
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I || !lk.cs_act) begin
      state_q <= tapi_pkg::TAPI_IDLE; // R8
    end else begin
      state_q <= state_d;
    end
  end

  // result shift register and bit counter
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I || !lk.cs_act) begin
      res_q <= 12'h000;
      bits_left_q <= 4'h0;
      dout_q <= 1'b0;
    end else if (busy_go) begin
      // straight binary, short mode keeps the top bits
      res_q <= CONV_DATA_I; // R2
      bits_left_q <= res_len(short_q); // R3
      dout_q <= 1'b0;
    end else if (lk.sclk_fall && state_q == tapi_pkg::TAPI_BUSY) begin
      dout_q <= res_q[11]; // msb first R2
      res_q <= {res_q[10:0], 1'b0};
      bits_left_q <= bits_left_q - 4'h1;
    end else if (lk.sclk_fall && state_q == tapi_pkg::TAPI_SHIFT) begin
      if (bits_left_q != 4'h0) begin
        dout_q <= res_q[11];
        res_q <= {res_q[10:0], 1'b0};
        bits_left_q <= bits_left_q - 4'h1;
      end else begin
        dout_q <= 1'b0; // trailing zeros
      end
    end
  end

  // ----------------------------------------
  // power and reference
  // ----------------------------------------
  // reference follows the upper power bit only as busy rises
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      ref_on_q <= 1'b0;
    end else if (busy_go) begin
      ref_on_q <= power_select_q[1]; // R17 R9 R10
    end
  end

  // converter on while working, or held on by the lower power bit
  assign ADC_ON_O = lk.cs_act &
    ((state_q != tapi_pkg::TAPI_IDLE) | power_select_q[0]); // R5 R8 R16
  assign REF_ON_O = ref_on_q;

  // ----------------------------------------
  // sensor drive and outputs
  // ----------------------------------------
  assign ACQUIRE_O = (state_q == tapi_pkg::TAPI_ACQ);
  assign DRIVE_ON_O = ACQUIRE_O |
    (~single_q & (state_q != tapi_pkg::TAPI_IDLE)); // R6 R7
  assign BUSY_O = (state_q == tapi_pkg::TAPI_BUSY);
  assign BUSY_OE_O = lk.cs_act;
  assign DOUT_O = dout_q;
  assign DOUT_OE_O = lk.cs_act;
  assign CHANNEL_O = ch_q;
  assign SHORT_MODE_O = short_q;
  assign REF_SINGLE_O = single_q;
  assign meas_xy = (state_q != tapi_pkg::TAPI_IDLE) &
    ((ch_q == `TAPI_CH_XPOS) | (ch_q == `TAPI_CH_YPOS));

  // ----------------------------------------
  // pen touch path
  // ----------------------------------------
  tapi_pen_ctl u_pen (
    .clk_i (CLOCK_I),
    .rst_n_i (RST_N_I),
    .idle_i (state_q == tapi_pkg::TAPI_IDLE),
    .pwr_i (power_select_q),
    .meas_xy_i (meas_xy),
    .xp_low_i (lk.xp_low),
    .ym_gnd_o (YM_GND_O),
    .xp_link_o (XP_PEN_LINK_O),
    .pen_oe_o (PEN_TOUCH_IRQ_OE_O)
  );
  assign PEN_TOUCH_IRQ_N_O = 1'b0; // R14

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  a_cs_abandon_conv: assert property (!lk.cs_act |=> state_q == tapi_pkg::TAPI_IDLE) // R8
    else $error("conversion survived chip select high");
  a_ref_latch_busy: assert property ($changed(ref_on_q) |-> $past(busy_go)) // R17
    else $error("reference changed outside busy rise");
  a_ref_cs_hold: assert property (!lk.cs_act |=> $stable(ref_on_q)) // R9
    else $error("reference changed with chip select");
  a_short_len: assert property (busy_go |=>
      bits_left_q == (short_q ? `TAPI_SHORT_BITS : `TAPI_FULL_BITS)) // R3
    else $error("wrong result length");
  a_result_msb: assert property (lk.sclk_fall && BUSY_O && lk.cs_act |=>
      dout_q == $past(res_q[11])) // R2
    else $error("result msb not sent first");
  a_single_drive: assert property (single_q && state_q == tapi_pkg::TAPI_SHIFT |->
      !DRIVE_ON_O) // R6
    else $error("sensor driven during single-ended conversion");
  a_diff_drive: assert property (!single_q && state_q != tapi_pkg::TAPI_IDLE |->
      DRIVE_ON_O) // R7
    else $error("sensor not driven in differential mode");
  a_start_hunt: assert property (!rx_active_q && lk.sclk_rise && !lk.din |=>
      !rx_active_q && $stable(rx_sh_q)) // R19
    else $error("byte started without start bit");
  a_pen_full_off: assert property (power_select_q == `TAPI_PWR_FULL ##1
      power_select_q == `TAPI_PWR_FULL |-> !PEN_TOUCH_IRQ_OE_O) // R16
    else $error("pen active in full power");
  a_auto_pdown: assert property (lk.cs_act && state_q == tapi_pkg::TAPI_IDLE &&
      power_select_q == `TAPI_PWR_AUTO |-> !ADC_ON_O) // R5
    else $error("converter on in auto power-down idle");
endmodule

// ===== tapi_cfg.svh
// Purpose: constants of the touch converter control block
// Assumes: serial link sampled by the 40 MHz core clock
// Notes: definitions only
`ifndef TAPI_CFG_SVH
`define TAPI_CFG_SVH

// ----------------------------------------
// control byte layout
// ----------------------------------------
`define TAPI_CB_CH_MSB 6
`define TAPI_CB_CH_LSB 4
`define TAPI_CB_MODE 3
`define TAPI_CB_REFSEL 2
`define TAPI_CB_PWR_MSB 1
`define TAPI_CB_PWR_LSB 0
`define TAPI_CB_PAYLOAD 3'h7

// ----------------------------------------
// field values and lengths
// ----------------------------------------
`define TAPI_PWR_AUTO 2'h0
`define TAPI_PWR_FULL 2'h3
`define TAPI_PWR_RESET 2'h0
`define TAPI_FULL_BITS 4'hc
`define TAPI_SHORT_BITS 4'h8
`define TAPI_CH_XPOS 3'h5
`define TAPI_CH_YPOS 3'h1
`endif

// ===== tapi_pkg.sv
// Purpose: shared types of the touch converter control block
// Assumes: nothing
// Notes: conversion sequencer states
package tapi_pkg;
  typedef enum logic [1:0] {
    TAPI_IDLE,
    TAPI_ACQ,
    TAPI_BUSY,
    TAPI_SHIFT
  } tapi_conv_st_t;
endpackage

// ===== tapi_pin_if.sv
// Purpose: carries synchronised pin events between modules
// Assumes: one core clock
// Notes: edge events are one-cycle pulses, the rest are levels
`timescale 1ns/1ps
interface tapi_pin_if;
  logic sclk_rise; // serial clock rising edge seen
  logic sclk_fall; // serial clock falling edge seen
  logic cs_act; // chip select asserted (level)
  logic din; // synchronised serial data in
  logic xp_low; // x-plus sense reads low
  modport src (output sclk_rise, sclk_fall, cs_act, din, xp_low);
  modport dst (input sclk_rise, sclk_fall, cs_act, din, xp_low);
endinterface

// ===== tapi_link_sync.sv
// Purpose: two-flop synchronisers and serial clock edge finder
// Assumes: pins are asynchronous to the core clock
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module tapi_link_sync (
  input wire logic clk_i, // core clock
  input wire logic rst_n_i, // sync reset, active low
  input wire logic sclk_i, // serial clock pin
  input wire logic cs_n_i, // chip select pin, active low
  input wire logic din_i, // serial data pin
  input wire logic xp_i, // x-plus sense pin
  tapi_pin_if.src lk // synchronised events
);
  logic [3:0] meta_q; // first stage
  logic [3:0] sync_q; // second stage
  logic sclk_old_q; // previous serial clock level

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      // idle levels: x-plus high, chip select high, so no false touch
      meta_q <= 4'ha;
      sync_q <= 4'ha;
      sclk_old_q <= 1'b0;
    end else begin
      meta_q <= {xp_i, din_i, cs_n_i, sclk_i};
      sync_q <= meta_q;
      sclk_old_q <= sync_q[0];
    end
  end

  assign lk.sclk_rise = sync_q[0] & ~sclk_old_q;
  assign lk.sclk_fall = ~sync_q[0] & sclk_old_q;
  assign lk.cs_act = ~sync_q[1];
  assign lk.din = sync_q[2];
  assign lk.xp_low = ~sync_q[3];
endmodule

// ===== tapi_pen_ctl.sv
// Purpose: pen touch path and y-minus driver control
// Assumes: inputs already on the core clock
// Notes: the pen output only ever pulls low
`timescale 1ns/1ps
`include "tapi_cfg.svh"
module tapi_pen_ctl (
  input wire logic clk_i, // core clock
  input wire logic rst_n_i, // sync reset, active low
  input wire logic idle_i, // no measurement running
  input wire logic [1:0] pwr_i, // latched power selection
  input wire logic meas_xy_i, // x or y position measured
  input wire logic xp_low_i, // x-plus pulled low
  output logic ym_gnd_o, // y-minus driver to ground
  output logic xp_link_o, // x-plus tied to pen node
  output logic pen_oe_o // pen output pulls low
);
  logic pen_en; // pen detection allowed
  logic watch; // power-down touch watch

  assign pen_en = (pwr_i != `TAPI_PWR_FULL); // R16
  assign watch = idle_i & (pwr_i == `TAPI_PWR_AUTO);

  // ----------------------------------------
  // pen node switches
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ym_gnd_o <= 1'b0;
      xp_link_o <= 1'b0;
      pen_oe_o <= 1'b0;
    end else begin
      ym_gnd_o <= watch; // R11
      xp_link_o <= watch & ~meas_xy_i; // R13
      // touch current path or diode grounded while measuring
      pen_oe_o <= pen_en & ((watch & xp_low_i) | meas_xy_i); // R12 R13 R14
    end
  end
endmodule

// ===== tapi_host_model.sv
// Purpose: host serial controller model for the touch converter
// Assumes: serial clock made from the core clock, levels of half cycles
// Notes: serial clock stands low outside frames; one record per clock
`timescale 1ns/1ps
module tapi_host_model (
  input wire logic clk_i, // core clock
  input wire logic dout_i, // result pin
  input wire logic busy_i, // busy pin
  input wire logic acq_i, // acquisition phase
  input wire logic drive_i, // sensor drive
  input wire logic ref_i, // reference power
  output logic sclk_o, // serial clock to device
  output logic cs_n_o, // chip select, active low
  output logic din_o // control data to device
);
  // ----------------------------------------
  // per-clock records, index 0 at bit 39
  // ----------------------------------------
  logic [39:0] dv, bv, av, wv, rv; // dout, busy, acquire, drive, reference
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  // select or release the device, then let the pin settle
  task automatic select(input logic on);
    @(posedge clk_i);
    cs_n_o <= !on;
    repeat (4) @(posedge clk_i);
  endtask
  // n serial clocks, bits sent msb first, half core cycles per level
  task automatic xfer(input logic [39:0] bits, input int n, input int half);
    int i;
    dv = '0;
    bv = '0;
    av = '0;
    wv = '0;
    rv = '0;
    @(posedge clk_i);
    for (i = 0; i < n; i++) begin
      sclk_o <= 1'b0;
      din_o <= bits[39-i]; // start bit leads each byte
      repeat (half) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (half) @(posedge clk_i);
      dv[39-i] = dout_i; // sampled late in the high level
      bv[39-i] = busy_i;
      av[39-i] = acq_i;
      wv[39-i] = drive_i;
      rv[39-i] = ref_i;
    end
    sclk_o <= 1'b0;
    din_o <= 1'b0;
    repeat (half) @(posedge clk_i);
  endtask
endmodule

// ===== tapi_conv_ctl_bench.sv
// Purpose: self-checking bench of the touch converter control block
// Assumes: host model drives the serial link at 200 ns per clock
// Notes: pen line is open drain with a pull-up built here
`timescale 1ns/1ps
module tapi_conv_ctl_bench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0; // core clock
  logic rst_n = 1'b0; // reset, active low
  logic xp_sense; // panel x-plus level
  logic [11:0] conv_data; // converter code
  logic sclk, cs_n, din, dout, dout_oe, busy, busy_oe, acq, drv, ref_on;
  logic adc_on, short_m, single, ym_gnd, xp_link, pen_n, pen_oe;
  logic [2:0] chan; // selected channel
  wire pen_line = pen_oe ? pen_n : 1'b1; // pull-up when not pulled
  int n_fail = 0;
  int checked = 0;
  logic [2:0] pos [2] = '{3'h5, 3'h1}; // x and y position channels
  always #12.5 clk = ~clk;
  tapi_host_model tapi_host_model_i (.clk_i(clk), .dout_i(dout), .busy_i(busy),
    .acq_i(acq), .drive_i(drv), .ref_i(ref_on), .sclk_o(sclk), .cs_n_o(cs_n),
    .din_o(din));
  tapi_conv_ctl tapi_conv_ctl_i (.CLOCK_I(clk), .RST_N_I(rst_n), .SERIAL_CLOCK_IN_I(sclk),
    .CS_N_I(cs_n), .DIN_I(din), .XP_SENSE_I(xp_sense), .CONV_DATA_I(conv_data),
    .DOUT_O(dout), .DOUT_OE_O(dout_oe), .BUSY_O(busy), .BUSY_OE_O(busy_oe),
    .CHANNEL_O(chan), .ACQUIRE_O(acq), .DRIVE_ON_O(drv), .REF_ON_O(ref_on),
    .ADC_ON_O(adc_on), .SHORT_MODE_O(short_m), .REF_SINGLE_O(single),
    .YM_GND_O(ym_gnd), .XP_PEN_LINK_O(xp_link), .PEN_TOUCH_IRQ_N_O(pen_n),
    .PEN_TOUCH_IRQ_OE_O(pen_oe));
  // ----------------------------------------
  // checking tasks
  // ----------------------------------------
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // one conversion as seen by the host, shifted by leading idle clocks
  task automatic chk_conv(input logic [11:0] d, input logic m, input logic s, input int lead);
    logic [39:0] e_d, e_w;
    e_d = m ? {9'h0, d[11:4], 23'h0} : {9'h0, d, 19'h0};
    e_w = s ? 40'h0300000000 : (m ? 40'h03ff800000 : 40'h03fff80000);
    chk(tapi_host_model_i.dv, e_d >> lead);
    chk(tapi_host_model_i.bv, 40'h0080000000 >> lead);
    chk(tapi_host_model_i.av, 40'h0300000000 >> lead);
    chk(tapi_host_model_i.wv, e_w >> lead);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    close_out();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    xp_sense <= 1'b1;
    conv_data <= 12'ha5c;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(40'({ref_on, busy, dout, dout_oe, single, ym_gnd, xp_link}), 40'h07);
    $display("test reset done");
    // full resolution, single-ended, full power
    tapi_host_model_i.select(1'b1);
    chk(40'({dout_oe, busy_oe}), 40'h3);
    tapi_host_model_i.xfer({8'hb7, 32'h0}, 24, 4);
    chk_conv(12'ha5c, 1'b0, 1'b1, 0);
    chk(40'({ref_on, adc_on, short_m, single, chan}), 40'h6b);
    xp_sense <= 1'b0;
    repeat (6) @(posedge clk);
    chk(40'(pen_line), 40'h1);
    xp_sense <= 1'b1;
    $display("test full power done");
    // short, differential, reference off, nominal clock after idle zeros
    conv_data <= 12'h3c9;
    tapi_host_model_i.xfer({2'b00, 8'hb9, 30'h0}, 26, 4);
    chk_conv(12'h3c9, 1'b1, 1'b0, 2);
    chk(tapi_host_model_i.rv, 40'hffc0000000);
    chk(40'({ref_on, adc_on, short_m, single}), 40'h6);
    $display("test short mode done");
    // two conversions fifteen clocks apart
    conv_data <= 12'h801;
    tapi_host_model_i.xfer({8'hb7, 7'h0, 8'hb7, 17'h0}, 40, 4);
    chk(tapi_host_model_i.dv, {9'h0, 12'h801, 3'h0, 12'h801, 4'h0});
    chk(tapi_host_model_i.bv, 40'h0080010000);
    $display("test overlap done");
    // chip select raised mid-result
    tapi_host_model_i.xfer({8'hb6, 32'h0}, 14, 4);
    tapi_host_model_i.select(1'b0);
    chk(40'({dout_oe, busy_oe, acq, drv, adc_on, dout, ref_on}), 40'h01);
    tapi_host_model_i.select(1'b1);
    tapi_host_model_i.xfer(40'h0, 20, 4);
    chk(tapi_host_model_i.dv | tapi_host_model_i.bv, 40'h0);
    $display("test abort done");
    // reference off before release, then pen detection
    tapi_host_model_i.xfer({8'hb4, 32'h0}, 24, 4);
    chk(40'({adc_on, ref_on, ym_gnd, xp_link}), 40'h3);
    tapi_host_model_i.select(1'b0);
    chk(40'(ref_on), 40'h0);
    xp_sense <= 1'b0;
    repeat (6) @(posedge clk);
    chk(40'(pen_line), 40'h0);
    xp_sense <= 1'b1;
    repeat (6) @(posedge clk);
    chk(40'(pen_line), 40'h1);
    $display("test pen done");
    // position measurements ground the pen diode
    tapi_host_model_i.select(1'b1);
    for (int k = 0; k < 2; k++) begin
      fork
        tapi_host_model_i.xfer({1'b1, pos[k], 4'h0, 32'h0}, 24, 4);
        begin
          repeat (90) @(posedge clk);
          chk(40'({xp_link, pen_oe}), 40'h1);
        end
      join
    end
    tapi_host_model_i.select(1'b0);
    $display("test position done");
    close_out();
  end
endmodule
